//--- logic/input_capture_channels.sv
// input_capture_channels: up to eight capture channels behind an
// AXI4-Lite slave, with sticky interrupt flags and a wake pulse.
// assumes pins and timer buses are synchronous to aclk.
`timescale 1ns/10ps
module input_capture_channels
	import capture_pkg::*;
#(
	parameter int NUM_CH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [NUM_CH-1:0] capture_pin,
	input wire logic [15:0] timer2_count,
	input wire logic [15:0] timer3_count,
	input wire logic timer2_on,
	input wire logic timer3_on,
	input wire logic cpu_sleep,
	input wire logic cpu_idle,
	output logic [NUM_CH-1:0] channel_irq_flag,
	output logic irq,
	output logic wake
);

	function automatic decode_s decode(input logic [ADDR_W-1:0] addr);
		decode_s d;
		d.hit = 1'b0;
		d.kind = K_NONE;
		d.ch = 3'h0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (addr[ADDR_W-1:2] == VALUE_IDX[i]) begin
				d.hit = 1'b1;
				d.kind = K_VALUE;
				d.ch = 3'(i);
			end
			if (addr[ADDR_W-1:2] == CTRL_IDX[i]) begin
				d.hit = 1'b1;
				d.kind = K_CTRL;
				d.ch = 3'(i);
			end
		end
		if (addr[ADDR_W-1:2] == IRQ_STATUS_IDX) begin
			d.hit = 1'b1;
			d.kind = K_STATUS;
		end
		if (addr[ADDR_W-1:2] == IRQ_CLEAR_IDX) begin
			d.hit = 1'b1;
			d.kind = K_CLEAR;
		end
		if (addr[ADDR_W-1:2] == IRQ_ENABLE_IDX) begin
			d.hit = 1'b1;
			d.kind = K_ENABLE;
		end
		return d;
	endfunction

	function automatic logic edge_match(
		input logic [2:0] mode,
		input logic rise,
		input logic fall,
		input logic pre_last
	);
		logic m;
		m = 1'b0;
		case (mode)
			MODE_BOTH: m = rise | fall;
			MODE_FALL: m = fall;
			MODE_RISE: m = rise;
			MODE_RISE4: m = rise & pre_last;
			MODE_RISE16: m = rise & pre_last;
			MODE_INT_RISE: m = rise;
			default: m = 1'b0;
		endcase
		return m;
	endfunction

	// write channel: address and data held until both are present
	logic aw_held_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic w_held_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;

	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	logic [NUM_CH-1:0] irq_status_reg;
	logic [NUM_CH-1:0] irq_enable_reg;
	logic wake_reg;

	logic [15:0] ctrl_view [NUM_CH];
	logic [15:0] value_view [NUM_CH];
	logic [NUM_CH-1:0] irq_set;
	logic [NUM_CH-1:0] wake_set;

	wire aw_hs = awvalid && awready;
	wire w_hs = wvalid && wready;
	wire ar_hs = arvalid && arready;
	wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;

	wire decode_s wdec = decode(awaddr_reg);
	wire decode_s rdec = decode(araddr);

	wire [15:0] wlane_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	wire [15:0] wval16 = wdata_reg[15:0];
	wire wr_clear = do_write && wdec.hit && (wdec.kind == K_CLEAR) && wstrb_reg[0];
	wire wr_enable = do_write && wdec.hit && (wdec.kind == K_ENABLE) && wstrb_reg[0];
	wire [NUM_CH-1:0] clear_bits = wr_clear ? wdata_reg[NUM_CH-1:0] : '0;

	// a read of a value register pops that channel's fifo
	wire rd_pop = ar_hs && rdec.hit && (rdec.kind == K_VALUE);

	wire [15:0] rd_word = !rdec.hit ? 16'h0000 :
		(rdec.kind == K_VALUE) ? value_view[rdec.ch] :
		(rdec.kind == K_CTRL) ? ctrl_view[rdec.ch] :
		(rdec.kind == K_STATUS) ? 16'(irq_status_reg) :
		(rdec.kind == K_ENABLE) ? 16'(irq_enable_reg) :
		16'h0000;

	assign awready = !aw_held_reg && !bvalid_reg;
	assign wready = !w_held_reg && !bvalid_reg;
	assign arready = !rvalid_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			awaddr_reg <= '0;
		end else if (aw_hs) begin
			aw_held_reg <= 1'b1;
			awaddr_reg <= awaddr;
		end else if (do_write) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg <= 1'b0;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
		end else if (w_hs) begin
			w_held_reg <= 1'b1;
			wdata_reg <= wdata;
			wstrb_reg <= wstrb;
		end else if (do_write) begin
			w_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wdec.hit ? RESP_OKAY : RESP_DECERR;
		end else if (bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// empty-buffer reads return the stale head; software must not rely on it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= 32'(rd_word);
			rresp_reg <= rdec.hit ? RESP_OKAY : RESP_DECERR;
		end else if (rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// a new event beats a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_reg <= '0;
		end else begin
			irq_status_reg <= (irq_status_reg & ~clear_bits) | irq_set;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_enable_reg <= NUM_CH'(IRQ_ENABLE_RESET);
		end else if (wr_enable) begin
			irq_enable_reg <= wdata_reg[NUM_CH-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_reg <= 1'b0;
		end else begin
			wake_reg <= |wake_set;
		end
	end

	assign channel_irq_flag = irq_status_reg;
	assign irq = |(irq_status_reg & irq_enable_reg);
	assign wake = wake_reg;

	for (genvar c = 0; c < NUM_CH; c++) begin : chan
		logic [15:0] ctrl_reg;
		logic prev_pin_reg;
		logic [3:0] pscnt_reg;
		logic [1:0] evcnt_reg;
		logic ovf_reg;
		logic fifo_empty;
		logic fifo_full;
		logic [15:0] head;

		wire [2:0] mode = ctrl_reg[MODE_LSB +: 3];
		wire [1:0] count_sel = ctrl_reg[ICNT_LSB +: 2];
		wire tsel = ctrl_reg[TSEL_BIT];
		wire timer_on = tsel ? timer2_on : timer3_on;
		wire [15:0] stamp = tsel ? timer2_count : timer3_count;

		wire rise = capture_pin[c] && !prev_pin_reg;
		wire fall = !capture_pin[c] && prev_pin_reg;

		// idle needs the chosen timer running and stop-in-idle clear
		wire full_func = !cpu_sleep &&
			!(cpu_idle && (ctrl_reg[SIDL_BIT] || !timer_on));
		// low power with mode 111: pin is only an interrupt source
		wire int_only = (cpu_sleep || cpu_idle) && (mode == MODE_INT_RISE);
		wire run = full_func && !int_only;

		wire pre_last = (mode == MODE_RISE4) ? (pscnt_reg == PRESCALE4_LAST) :
			(pscnt_reg == PRESCALE16_LAST);
		wire pre_step = run && rise &&
			((mode == MODE_RISE4) || (mode == MODE_RISE16));
		wire cap_evt = run && edge_match(mode, rise, fall, pre_last);
		wire live_evt = cap_evt && !ovf_reg;

		wire push = live_evt && !fifo_full;
		wire ovf_now = live_evt && fifo_full && (mode != MODE_BOTH);
		wire count_hit = (evcnt_reg == count_sel);
		wire both_irq = live_evt && (mode == MODE_BOTH);
		wire count_irq = live_evt && (mode != MODE_BOTH) && count_hit;

		assign irq_set[c] = both_irq || count_irq || (int_only && rise);
		assign wake_set[c] = int_only && rise && irq_enable_reg[c];

		wire ctrl_we = do_write && wdec.hit && (wdec.kind == K_CTRL) && (wdec.ch == 3'(c));
		wire [15:0] wmask = CTRL_WMASK & wlane_mask;

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ctrl_reg <= CTRL_RESET;
				prev_pin_reg <= 1'b0;
			end else begin
				prev_pin_reg <= capture_pin[c];
				if (ctrl_we) begin
					ctrl_reg <= (ctrl_reg & ~wmask) | (wval16 & wmask);
				end
			end
		end

		// prescaler restarts whenever the channel is switched off
		always_ff @(posedge aclk) begin
			if (!aresetn || (mode == MODE_OFF)) begin
				pscnt_reg <= 4'h0;
			end else if (pre_step) begin
				pscnt_reg <= pre_last ? 4'h0 : pscnt_reg + 4'h1;
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn || (mode == MODE_OFF)) begin
				evcnt_reg <= 2'h0;
			end else if (live_evt && (mode != MODE_BOTH)) begin
				evcnt_reg <= count_hit ? 2'h0 : evcnt_reg + 2'h1;
			end
		end

		// overflow doubles as the capture lockout until drained
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ovf_reg <= 1'b0;
			end else if (ovf_now) begin
				ovf_reg <= 1'b1;
			end else if (ovf_reg && fifo_empty) begin
				ovf_reg <= 1'b0;
			end
		end

		capture_fifo #(
			.WIDTH(VALUE_W),
			.DEPTH(FIFO_DEPTH)
		) fifo (
			.aclk(aclk),
			.aresetn(aresetn),
			.push(push),
			.push_data(stamp),
			.pop(rd_pop && (rdec.ch == 3'(c))),
			.head_data(head),
			.empty(fifo_empty),
			.full(fifo_full)
		);

		assign value_view[c] = head;
		assign ctrl_view[c] = (ctrl_reg & CTRL_WMASK) |
			(16'(ovf_reg) << OVF_BIT) |
			(16'(!fifo_empty) << BNE_BIT);
	end

endmodule

//--- logic/capture_pkg.sv
// capture_pkg: register map, field layout and mode codes of the
// input capture block; shared by the top, its checker and its bench.
package capture_pkg;

	localparam int ADDR_W = 12;
	localparam int VALUE_W = 16;
	localparam int FIFO_DEPTH = 4;
	localparam int MAX_CH = 8;

	// printed offsets are word indices; byte address is index * 4
	localparam logic [9:0] VALUE_IDX [MAX_CH] = '{10'h140, 10'h144, 10'h148, 10'h14C,
		10'h150, 10'h154, 10'h158, 10'h15C};
	localparam logic [9:0] CTRL_IDX [MAX_CH] = '{10'h142, 10'h146, 10'h14A, 10'h14E,
		10'h152, 10'h156, 10'h15A, 10'h15E};
	localparam logic [9:0] IRQ_STATUS_IDX = 10'h160;
	localparam logic [9:0] IRQ_CLEAR_IDX = 10'h161;
	localparam logic [9:0] IRQ_ENABLE_IDX = 10'h162;

	localparam int MODE_LSB = 0;
	localparam int BNE_BIT = 3;
	localparam int OVF_BIT = 4;
	localparam int ICNT_LSB = 5;
	localparam int TSEL_BIT = 7;
	localparam int SIDL_BIT = 13;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CTRL_WMASK = 16'h20E7;
	localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;

	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_BOTH = 3'h1;
	localparam logic [2:0] MODE_FALL = 3'h2;
	localparam logic [2:0] MODE_RISE = 3'h3;
	localparam logic [2:0] MODE_RISE4 = 3'h4;
	localparam logic [2:0] MODE_RISE16 = 3'h5;
	localparam logic [2:0] MODE_INT_RISE = 3'h7;

	localparam logic [3:0] PRESCALE4_LAST = 4'h3;
	localparam logic [3:0] PRESCALE16_LAST = 4'hF;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [2:0] {K_VALUE, K_CTRL, K_STATUS, K_CLEAR, K_ENABLE, K_NONE} reg_kind_e;

	typedef struct packed {
		logic hit;
		reg_kind_e kind;
		logic [2:0] ch;
	} decode_s;

endpackage

//--- logic/capture_fifo.sv
// capture_fifo: shift-forward buffer, head always at slot 0.
// assumes pop is only honoured when not empty; push on full is dropped unless a pop comes in the same cycle.
`timescale 1ns/10ps
module capture_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	input wire logic pop,
	output logic [WIDTH-1:0] head_data,
	output logic empty,
	output logic full
);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] slot_reg [DEPTH];
	logic [CW-1:0] count_reg;

	wire do_pop = pop && (count_reg != '0);
	wire do_push = push && ((count_reg != CW'(DEPTH)) || do_pop);
	wire [CW-1:0] wr_idx = count_reg - CW'(do_pop);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_reg <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				slot_reg[i] <= '0;
			end
		end else begin
			count_reg <= count_reg + CW'(do_push) - CW'(do_pop);
			for (int i = 0; i < DEPTH; i++) begin
				if (do_push && (wr_idx == CW'(i))) begin
					slot_reg[i] <= push_data;
				end else if (do_pop && (i < DEPTH - 1)) begin
					slot_reg[i] <= slot_reg[i + 1];
				end
			end
		end
	end

	assign head_data = slot_reg[0];
	assign empty = (count_reg == '0);
	assign full = (count_reg == CW'(DEPTH));
endmodule

//--- verification/capture_partner.sv
// capture_partner: the two shared timers seen by the capture block.
// assumes run levels come from the bench; counts freeze while stopped.
`timescale 1ns/10ps
module capture_partner (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run2,
	input wire logic run3,
	output logic [15:0] timer2_count,
	output logic [15:0] timer3_count,
	output logic timer2_on,
	output logic timer3_on
);
	assign timer2_on = run2;
	assign timer3_on = run3;
	// distinct steps so a wrong timer choice shows in the stamp
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer2_count <= 16'h2000;
			timer3_count <= 16'h3000;
		end else begin
			if (run2) timer2_count <= timer2_count + 16'h0001;
			if (run3) timer3_count <= timer3_count + 16'h0007;
		end
	end
endmodule

//--- verification/input_capture_channels_assertions.sv
// input_capture_channels_assertions: port-level checker of the capture block.
// assumes one clock aclk and synchronous active-low aresetn.
`timescale 1ns/10ps
module input_capture_channels_assertions
	import capture_pkg::*;
#(
	parameter int NUM_CH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wvalid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [NUM_CH-1:0] capture_pin,
	input wire logic cpu_sleep,
	input wire logic cpu_idle,
	input wire logic [NUM_CH-1:0] channel_irq_flag,
	input wire logic irq,
	input wire logic wake
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_read_latency: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read answer dropped");
	a_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	a_value_width: assert property (rvalid |-> rdata[31:16] == 16'h0000)
		else $error("upper data bits set");
	a_irq_source: assert property (irq |-> |channel_irq_flag)
		else $error("irq without flag");
	a_wake_pulse: assert property (wake |=> !wake)
		else $error("wake longer than one cycle");
	a_wake_power: assert property (wake |-> $past(cpu_sleep || cpu_idle))
		else $error("wake outside sleep or idle");
	// latency of pin to flag may be one to three edges
	a_flag_cause: assert property (|(channel_irq_flag & ~$past(channel_irq_flag)) |->
		$past(capture_pin) != $past(capture_pin, 2) || $past(capture_pin, 2) != $past(capture_pin, 3) ||
		$past(capture_pin, 3) != $past(capture_pin, 4))
		else $error("flag set without pin edge");
	a_flag_sticky: assert property (|($past(channel_irq_flag) & ~channel_irq_flag) |->
		$past(wvalid) || $past(wvalid, 2))
		else $error("flag dropped without write");
	cover property (wake);
	cover property (irq);
	cover property (rvalid && rresp == RESP_DECERR);
endmodule

bind input_capture_channels input_capture_channels_assertions #(.NUM_CH(NUM_CH)) i_input_capture_channels_assertions (
	.aclk, .aresetn, .wvalid, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .bresp, .bvalid,
	.bready, .capture_pin, .cpu_sleep, .cpu_idle, .channel_irq_flag, .irq, .wake
);

//--- verification/input_capture_channels_test.sv
// input_capture_channels_test: random and corner-case bench of the block.
// assumes the partner drives the timers; pins are driven here.
`timescale 1ns/10ps
module input_capture_channels_test;
	import capture_pkg::*;
	localparam logic [11:0] ST_A = {IRQ_STATUS_IDX, 2'b00};
	localparam logic [11:0] CL_A = {IRQ_CLEAR_IDX, 2'b00};
	localparam logic [11:0] EN_A = {IRQ_ENABLE_IDX, 2'b00};
	logic aclk = 0, aresetn = 0, cpu_sleep = 0, cpu_idle = 0, run2 = 0, run3 = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, d;
	logic [7:0] capture_pin = 0, channel_irq_flag;
	logic awready, wready, bvalid, arready, rvalid, irq, wake, timer2_on, timer3_on;
	logic [1:0] bresp, rresp, r;
	logic [15:0] timer2_count, timer3_count;
	logic [2:0] md [5] = '{MODE_FALL, MODE_RISE, MODE_BOTH, MODE_RISE4, MODE_RISE16};
	int np [5] = '{2, 3, 2, 8, 32};
	int fails = 0, checked = 0, wakes = 0, c, ts, k;
	logic [31:0] q [$];
	input_capture_channels #(.NUM_CH(8)) i_input_capture_channels (
		.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .capture_pin, .timer2_count, .timer3_count, .timer2_on, .timer3_on,
		.cpu_sleep, .cpu_idle, .channel_irq_flag, .irq, .wake
	);
	capture_partner i_capture_partner (
		.aclk, .aresetn, .run2, .run3, .timer2_count, .timer3_count, .timer2_on, .timer3_on
	);
	initial forever #12.5 aclk = ~aclk;
	always @(posedge aclk) if (wake) wakes++;
	function automatic logic [11:0] ca(int ch);
		return {CTRL_IDX[ch], 2'b00};
	endfunction
	function automatic logic [11:0] va(int ch);
		return {VALUE_IDX[ch], 2'b00};
	endfunction
	function automatic logic [31:0] cw(logic [2:0] m, int ic, int tsel, int sd);
		return {16'h0000, 2'b00, sd[0], 5'h00, tsel[0], ic[1:0], 2'b00, m};
	endfunction
	function automatic int caps(logic [2:0] m, int n);
		return m == MODE_BOTH ? 2 * n : m == MODE_RISE4 ? n / 4 : m == MODE_RISE16 ? n / 16 : n;
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		logic ad, dd;
		ad = 0;
		dd = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(ad && dd)) begin
			@(posedge aclk);
			if (awvalid && awready) ad = 1;
			if (wvalid && wready) dd = 1;
			if (ad) awvalid <= 0;
			if (dd) wvalid <= 0;
		end
		do @(posedge aclk); while (!bvalid);
		bready <= 0;
		r = bresp;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		do @(posedge aclk); while (!rvalid);
		rready <= 0;
		d = rdata;
		r = rresp;
	endtask
	task automatic pulse(int ch, int n);
		repeat (n) begin
			@(posedge aclk);
			capture_pin[ch] <= 1;
			repeat (3) @(posedge aclk);
			capture_pin[ch] <= 0;
			repeat (2) @(posedge aclk);
		end
		repeat (6) @(posedge aclk);
	endtask
	task automatic drain(int ch, output int n);
		n = 0;
		rd(ca(ch));
		while (d[BNE_BIT] && n < 6) begin
			rd(va(ch));
			n++;
			rd(ca(ch));
		end
	endtask
	task automatic final_report;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge aclk);
		fails++;
		final_report;
	end
	initial begin
		void'($urandom(90));
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		for (int i = 0; i < 8; i++) begin
			rd(ca(i));
			chk("ctrl reset", 32'(CTRL_RESET), d);
		end
		rd(EN_A);
		chk("enable reset", 32'(IRQ_ENABLE_RESET), d);
		rd(12'hFFC);
		chk("unmapped", 32'(RESP_DECERR), r);
		wr(12'hFFC, 32'h0000FFFF);
		chk("unmapped write", 32'(RESP_DECERR), r);
		c = $urandom_range(7);
		ts = $urandom_range(1);
		wr(ca(c), 32'h0000FFFF);
		chk("write okay", 32'(RESP_OKAY), r);
		rd(ca(c));
		chk("ctrl mask", 32'(CTRL_WMASK), d);
		wr(ca(c), cw(MODE_RISE, 0, ts, 0));
		for (int i = 0; i < 6; i++) begin
			run2 <= 1;
			run3 <= 1;
			repeat ($urandom_range(20, 3)) @(posedge aclk);
			run2 <= 0;
			run3 <= 0;
			@(posedge aclk);
			if (i < 4) q.push_back(ts ? 32'(timer2_count) : 32'(timer3_count));
			pulse(c, 1);
			rd(ca(c));
			chk("overflow", i >= 4, d[OVF_BIT]);
		end
		for (int i = 0; i < 4; i++) begin
			rd(ca(c));
			chk("not empty", 1, d[BNE_BIT]);
			rd(va(c));
			chk("stamp", q[i], d);
		end
		rd(ca(c));
		chk("drained", 0, d[4:3]);
		pulse(c, 1);
		drain(c, k);
		chk("after drain", 1, k);
		foreach (md[j]) begin
			wr(ca(c), cw(md[j], 0, 0, 0));
			pulse(c, np[j]);
			drain(c, k);
			chk("captures", caps(md[j], np[j]), k);
			wr(ca(c), 0);
		end
		wr(ca(c), cw(MODE_RISE4, 0, 0, 0));
		pulse(c, 3);
		wr(ca(c), 0);
		wr(ca(c), cw(MODE_RISE4, 0, 0, 0));
		pulse(c, 1);
		drain(c, k);
		chk("prescale cleared", 0, k);
		wr(ca(c), cw(MODE_BOTH, 3, 0, 0));
		wr(CL_A, 32'hFF);
		@(posedge aclk);
		capture_pin[c] <= 1;
		repeat (6) @(posedge aclk);
		chk("every edge flag", 1, channel_irq_flag[c]);
		capture_pin[c] <= 0;
		// six edges into a four-deep buffer: extra ones must drop silently
		pulse(c, 2);
		rd(ca(c));
		chk("no overflow", 0, d[OVF_BIT]);
		drain(c, k);
		chk("every edge", 4, k);
		wr(ca(c), 0);
		wr(EN_A, 32'(1 << c));
		for (int ic = 0; ic < 4; ic++) begin
			wr(ca(c), cw(MODE_RISE, ic, 0, 0));
			wr(CL_A, 32'hFF);
			pulse(c, ic);
			chk("early irq", 0, irq);
			pulse(c, 1);
			chk("flag", 1, channel_irq_flag[c]);
			chk("irq", 1, irq);
			drain(c, k);
			wr(ca(c), 0);
		end
		wr(EN_A, 0);
		chk("masked", 0, irq);
		rd(ST_A);
		chk("status", 32'(1 << c), d);
		wr(CL_A, 32'(1 << c));
		rd(ST_A);
		chk("cleared", 0, d);
		wr(EN_A, 32'(1 << c));
		for (int p = 0; p < 2; p++) begin
			cpu_sleep <= (p == 0);
			cpu_idle <= (p == 1);
			wr(CL_A, 32'hFF);
			wr(ca(c), cw(MODE_INT_RISE, p ? 0 : 3, 0, 0));
			wakes = 0;
			pulse(c, 1);
			chk("wake", 1, wakes);
			chk("int only flag", 1, channel_irq_flag[c]);
			rd(ca(c));
			chk("int only store", 0, d[BNE_BIT]);
			wr(ca(c), 0);
		end
		for (int i = 0; i < 4; i++) begin
			cpu_sleep <= (i == 3);
			cpu_idle <= (i != 3);
			run3 <= (i != 2);
			wr(ca(c), cw(MODE_RISE, 0, 0, i == 1));
			pulse(c, 1);
			cpu_sleep <= 0;
			cpu_idle <= 0;
			drain(c, k);
			chk("power capture", i == 0, k);
			wr(ca(c), 0);
		end
		final_report;
	end
endmodule
